// [rtl/dtb_timer.sv]
// dual count-up timer block with timer 1 overflow as uart baud tick
// ----------------------------------------------------------------------------
// What this block does
// [R1] count up once per two clocks
// [R2] mode 0: 8-bit counter after divide-by-32
// [R3] mode 1: low and high form 16 bits
// [R4] mode 2: low reloads from high on overflow
// [R5] mode 3: timer 0 splits into two counters
// [R6] timer 1 halts in mode 3
// [R7] modes 0-2: timers run independently
// [R8] timer 1 overflow feeds uart modes 1,3
// [R9] software should prefer mode 2 for baud
// [R10] baud = 2^double*clk/(32*2*(256-high))
// [R11] sticky overflow flags, split gets own flag
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
module dtb_timer (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire dtb_pkg::dtb_ctrl_s ctrl0_i,
  input  wire dtb_pkg::dtb_ctrl_s ctrl1_i,
  input  wire logic              split_run_i,       // run for timer 0 high byte in mode 3
  input  wire logic [2:0]        flag_clr_i,        // 0: timer0, 1: timer1, 2: split high
  input  wire logic [1:0]        uart_mode_i,
  input  wire logic              baud_double_select_i,
  output dtb_pkg::dtb_stat_s     stat0_o,
  output dtb_pkg::dtb_stat_s     stat1_o,
  output logic                   split_flag_o,
  output logic                   irq_o,
  output logic                   baud_tick_o          // one pulse per baud rate tick
);
  import dtb_pkg::*;

  // --------------------------------------------------------------------------
  // machine cycle
  // --------------------------------------------------------------------------
  logic phase_ff;
  logic nxt_phase;
  logic mcyc;

  always_comb begin
    nxt_phase = ~phase_ff;
  end
  assign mcyc = phase_ff;  // every second clock [R1]

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // --------------------------------------------------------------------------
  // counters
  // --------------------------------------------------------------------------
  logic [7:0] low_ff   [2];
  logic [7:0] high_ff  [2];
  logic [4:0] pre_ff   [2];
  logic [2:0] flag_ff;
  logic [7:0] nxt_low  [2];
  logic [7:0] nxt_high [2];
  logic [4:0] nxt_pre  [2];
  logic [2:0] nxt_flag;
  logic [2:0] ovf;
  logic       half_ff;
  logic       nxt_half;
  dtb_ctrl_s  ctl [2];

  assign ctl[0] = ctrl0_i;
  assign ctl[1] = ctrl1_i;

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      nxt_low[t]  = low_ff[t];
      nxt_high[t] = high_ff[t];
      nxt_pre[t]  = pre_ff[t];
      ovf[t]      = 1'b0;
      // each timer sees only its own controls [R7]
      if (ctl[t].load) begin
        nxt_low[t]  = ctl[t].load_low;
        nxt_high[t] = ctl[t].load_high;
        nxt_pre[t]  = DTB_PRE_RST;
      end else if (mcyc && ctl[t].run && !(t == 1 && ctl[t].mode == DTB_MODE_SPLIT)) begin // [R6]
        unique case (ctl[t].mode)
          DTB_MODE_13BIT: begin
            nxt_pre[t] = pre_ff[t] + 5'h01;  // [R2]
            if (pre_ff[t] == DTB_PRE_MAX) begin
              nxt_high[t] = high_ff[t] + 8'h01;
              ovf[t]      = (high_ff[t] == DTB_BYTE_MAX);
            end
          end
          DTB_MODE_16BIT: begin
            nxt_low[t] = low_ff[t] + 8'h01;  // [R3]
            if (low_ff[t] == DTB_BYTE_MAX) begin
              nxt_high[t] = high_ff[t] + 8'h01;
              ovf[t]      = (high_ff[t] == DTB_BYTE_MAX);
            end
          end
          DTB_MODE_RELOAD: begin
            ovf[t]     = (low_ff[t] == DTB_BYTE_MAX);
            nxt_low[t] = ovf[t] ? high_ff[t] : low_ff[t] + 8'h01;  // [R4]
          end
          DTB_MODE_SPLIT: begin
            nxt_low[t] = low_ff[t] + 8'h01;  // [R5]
            ovf[t]     = (low_ff[t] == DTB_BYTE_MAX);
          end
        endcase
      end
    end
    // split high byte of timer 0 counts on its own run input
    ovf[2] = 1'b0;
    if (!ctl[0].load && mcyc && split_run_i && ctl[0].mode == DTB_MODE_SPLIT) begin
      nxt_high[0] = high_ff[0] + 8'h01;  // [R5]
      ovf[2]      = (high_ff[0] == DTB_BYTE_MAX);
    end
    // set wins over clear
    nxt_flag = (flag_ff & ~flag_clr_i) | ovf;  // [R11]
    // divide by 2 after the overflow, double rate bypasses it [R10]
    nxt_half = half_ff ^ ovf[1];
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int t = 0; t < 2; t++) begin
        low_ff[t]  <= DTB_BYTE_RST;
        high_ff[t] <= DTB_BYTE_RST;
        pre_ff[t]  <= DTB_PRE_RST;
      end
      flag_ff <= 3'h0;
      half_ff <= 1'b0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        low_ff[t]  <= nxt_low[t];
        high_ff[t] <= nxt_high[t];
        pre_ff[t]  <= nxt_pre[t];
      end
      flag_ff <= nxt_flag;
      half_ff <= nxt_half;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  logic baud_ff;
  logic nxt_baud;
  logic uart_var;

  // uart consumes this tick and divides by 16 itself; software picks mode 2 [R9]
  assign uart_var = (uart_mode_i == 2'd1) || (uart_mode_i == 2'd3);
  always_comb begin
    nxt_baud = uart_var && ovf[1] && (baud_double_select_i || half_ff);  // [R8] [R10]
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      baud_ff <= 1'b0;
    end else begin
      baud_ff <= nxt_baud;
    end
  end

  assign baud_tick_o      = baud_ff;
  assign stat0_o          = '{low: low_ff[0], high: high_ff[0], ovf_flag: flag_ff[0]};
  assign stat1_o          = '{low: low_ff[1], high: high_ff[1], ovf_flag: flag_ff[1]};
  assign split_flag_o     = flag_ff[2];
  assign irq_o            = |flag_ff;  // [R11]

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  sequence t1_halted_s;
    ctrl1_i.mode == DTB_MODE_SPLIT && !ctrl1_i.load;
  endsequence

  // first step of a double-rate tick: timer 1 wraps while the uart takes variable rate
  sequence t1_wrap_dbl_s;
    uart_var && ovf[1] && baud_double_select_i;
  endsequence

  timer1_halt_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R6]
    t1_halted_s |=> $stable(low_ff[1]) && $stable(high_ff[1]))
    else $error("timer 1 moved in mode 3");

  mcyc_rate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R1]
    mcyc |=> !mcyc)
    else $error("machine cycle not every second clock");

  // timer 1 running in mode 2 must hold its low byte still on the clock between two machine cycles
  count_rate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R1]
    !ctrl1_i.load && ctrl1_i.run && ctrl1_i.mode == DTB_MODE_RELOAD && !mcyc
    |=> $stable(low_ff[1]))
    else $error("timer counted off the machine cycle");

  reload_value_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R4]
    !ctrl0_i.load && ctrl0_i.mode == DTB_MODE_RELOAD && ovf[0]
    |=> low_ff[0] == $past(high_ff[0]))
    else $error("reload value not taken");

  flag_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R11]
    ovf[1] |=> flag_ff[1] && irq_o)
    else $error("overflow flag not set");

  split_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R11]
    ovf[2] |=> split_flag_o && irq_o)
    else $error("split overflow flag not set");

  baud_mode_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R8]
    baud_tick_o |-> $past(uart_var) && $past(ovf[1]))
    else $error("baud tick without overflow");

  baud_double_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R10]
    t1_wrap_dbl_s |=> baud_tick_o)
    else $error("double rate missed a baud tick");

  count16_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R3]
    !ctrl0_i.load && ctrl0_i.run && ctrl0_i.mode == DTB_MODE_16BIT && mcyc
    |=> {high_ff[0], low_ff[0]} == 16'($past({high_ff[0], low_ff[0]}) + 16'h0001))
    else $error("16-bit count wrong");

  pre_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R2]
    !ctrl1_i.load && ctrl1_i.mode == DTB_MODE_13BIT && pre_ff[1] != DTB_PRE_MAX
    |=> $stable(high_ff[1]))
    else $error("13-bit high stage moved before prescale end");

  mode0_step_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R2]
    !ctrl1_i.load && ctrl1_i.run && ctrl1_i.mode == DTB_MODE_13BIT && mcyc
    && pre_ff[1] == DTB_PRE_MAX |=> high_ff[1] == 8'($past(high_ff[1]) + 8'h01))
    else $error("13-bit high stage missed its step");

  split_run_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [R5] [R7]
    !ctrl0_i.load && ctrl0_i.mode == DTB_MODE_SPLIT && !split_run_i
    |=> $stable(high_ff[0]))
    else $error("split high byte moved without its run");

endmodule : dtb_timer

// [rtl/dtb_pkg.sv]
// package: types and constants for the dual timer with baud overflow
package dtb_pkg;

  // --------------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------------
  localparam int unsigned DTB_MCYC_DIV   = 2;     // clocks per machine cycle
  localparam int unsigned DTB_PRE_W      = 5;     // mode 0 prescaler width (divide by 32)
  localparam logic [7:0]  DTB_BYTE_RST   = 8'h00;
  localparam logic [7:0]  DTB_BYTE_MAX   = 8'hFF;
  localparam logic [4:0]  DTB_PRE_MAX    = 5'h1F;
  localparam logic [4:0]  DTB_PRE_RST    = 5'h00;

  typedef enum logic [1:0] {
    DTB_MODE_13BIT,
    DTB_MODE_16BIT,
    DTB_MODE_RELOAD,
    DTB_MODE_SPLIT
  } dtb_mode_e;

  // software-side control of one timer
  typedef struct packed {
    logic       run;
    dtb_mode_e  mode;
    logic       load;       // one-cycle pulse: load count from load_low and load_high
    logic [7:0] load_low;
    logic [7:0] load_high;
  } dtb_ctrl_s;

  // visible state of one timer
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf_flag;
  } dtb_stat_s;

endpackage : dtb_pkg

// [test/dtb_uart_model.sv]
// partner: uart end that consumes the timer 1 baud ticks
`timescale 1ns/1ps
module dtb_uart_model (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       baud_tick_i,
  output int              tick_cnt_o
);
  // every tick is counted, so a tick leaking out in a fixed-rate mode shows up
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_o <= 0;
    end else if (baud_tick_i) begin
      tick_cnt_o <= tick_cnt_o + 1;
    end
  end
endmodule : dtb_uart_model

// [test/tb.sv]
// testbench: random and corner checks of the dual timer block
`timescale 1ns/1ps
module tb;
  import dtb_pkg::*;
  dtb_ctrl_s  ctrl0, ctrl1;
  dtb_stat_s  stat0, stat1;
  logic       clk_i, reset_n_i, split_run, dbl, split_flag, irq, baud_tick;
  logic [2:0] flag_clr;
  logic [1:0] uart_mode;
  logic [7:0] a, h;
  logic [8:0] e;
  int         err_total, tests_run, ticks, t;
  integer     seed = 32'h5195879E;
  dtb_timer i_dtb_timer (.clk_i(clk_i), .reset_n_i(reset_n_i), .ctrl0_i(ctrl0),
    .ctrl1_i(ctrl1), .split_run_i(split_run), .flag_clr_i(flag_clr), .uart_mode_i(uart_mode),
    .baud_double_select_i(dbl), .stat0_o(stat0), .stat1_o(stat1), .split_flag_o(split_flag),
    .irq_o(irq), .baud_tick_o(baud_tick));
  dtb_uart_model i_dtb_uart_model (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .baud_tick_i(baud_tick), .tick_cnt_o(ticks));
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // bit 8 tells whether the 8-bit reload counter wrapped at least once
  function automatic logic [8:0] reload(input logic [7:0] lo, rl, input int n);
    logic w;
    w = 1'b0;
    repeat (n) begin
      w = w | (lo == 8'hFF);
      lo = (lo == 8'hFF) ? rl : lo + 8'h01;
    end
    return {w, lo};
  endfunction : reload
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task setup(input dtb_mode_e m0, m1, input logic [7:0] l0, h0, l1, h1);
    @(negedge clk_i);
    ctrl0 = '{1'b0, m0, 1'b1, l0, h0};
    ctrl1 = '{1'b0, m1, 1'b1, l1, h1};
    flag_clr = 3'h7;
    @(negedge clk_i);
    ctrl0.load = 1'b0;
    ctrl1.load = 1'b0;
    flag_clr = 3'h0;
  endtask : setup
  // an even clock count gives exactly n counts whatever the machine-cycle phase
  task run(input logic r0, r1, sr, input int n);
    ctrl0.run = r0;
    ctrl1.run = r1;
    split_run = sr;
    repeat (2 * n) @(negedge clk_i);
    ctrl0.run = 1'b0;
    ctrl1.run = 1'b0;
    split_run = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : run
  task results;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // ----------------------------------------------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results();
  end
  initial begin
    {ctrl0, ctrl1, split_run, flag_clr, uart_mode, dbl} = '0;
    reset_n_i = 1'b0;
    repeat (6) @(negedge clk_i);
    reset_n_i = 1'b1;
    a = 8'($random(seed));
    h = 8'($random(seed));
    setup(DTB_MODE_16BIT, DTB_MODE_RELOAD, 8'hF0, 8'h12, a, h);
    run(1'b1, 1'b1, 1'b0, 20);
    e = reload(a, h, 20);
    check({stat0.high, stat0.low}, 16'h1304);
    check({stat1.ovf_flag, stat1.high, stat1.low}, {e[8], h, e[7:0]});
    setup(DTB_MODE_16BIT, DTB_MODE_16BIT, 8'hFE, 8'hFF, 8'h00, 8'h00);
    run(1'b1, 1'b0, 1'b0, 3);
    check({irq, stat0}, {1'b1, 8'h01, 8'h00, 1'b1});
    check(stat1, 17'h0);
    flag_clr = 3'h1;
    @(negedge clk_i);
    flag_clr = 3'h0;
    check({irq, stat0.ovf_flag}, 2'b00);
    setup(DTB_MODE_13BIT, DTB_MODE_13BIT, 8'h00, h, 8'h00, 8'hFF);
    run(1'b1, 1'b1, 1'b0, 64);
    check({stat0.high, stat1.high, stat1.ovf_flag}, {h + 8'h02, 8'h01, 1'b1});
    setup(DTB_MODE_SPLIT, DTB_MODE_SPLIT, a, 8'hFA, 8'h55, 8'h66);
    run(1'b1, 1'b1, 1'b1, 10);
    e = reload(a, 8'h00, 10);
    check({stat0.low, stat0.ovf_flag}, {e[7:0], e[8]});
    check({stat0.high, split_flag}, {8'h04, 1'b1});
    check(stat1, {8'h55, 8'h66, 1'b0});
    // timer 1 in reload mode as the baud source, four overflows per window
    for (int m = 0; m < 8; m++) begin
      h = 8'hF0 | 8'($random(seed) & 15);
      a = (m == 0) ? 8'hFF : 8'($random(seed));  // first pass wraps timer 0 at once
      setup(DTB_MODE_RELOAD, DTB_MODE_RELOAD, a, 8'hE0 | a, h, h);
      uart_mode = 2'(m >> 1);
      dbl = m[0];
      t = ticks;
      run(1'b1, 1'b1, 1'b0, 4 * (256 - h));
      e = reload(a, 8'hE0 | a, 4 * (256 - h));
      check(16'(ticks - t), uart_mode[0] ? (dbl ? 16'h4 : 16'h2) : 16'h0);
      check({stat0.ovf_flag, stat0.high, stat0.low}, {e[8], 8'hE0 | a, e[7:0]});
    end
    results();
  end
endmodule : tb
